//--- hdl/smcg_cfg.svh
`ifndef SMCG_CFG_SVH
`define SMCG_CFG_SVH
`define SMCG_MODE_IDLE      3'h0
`define SMCG_MODE_ADC_NR    3'h1
`define SMCG_MODE_PDOWN     3'h2
`define SMCG_MODE_PSAVE     3'h3
`define SMCG_MODE_RSV4      3'h4
`define SMCG_MODE_RSV5      3'h5
`define SMCG_MODE_STBY      3'h6
`define SMCG_MODE_XSTBY     3'h7
`define SMCG_PERMIT_BIT     6
`define SMCG_STALL_CYC      4
`define SMCG_STBY_WAKE_CYC  6
`define SMCG_CNT_W          16
`endif

//--- hdl/smcg_pkg.sv
package smcg_pkg;
  typedef enum logic [2:0] {
    SMCG_ST_RUN,
    SMCG_ST_SLEEP,
    SMCG_ST_START,
    SMCG_ST_STALL
  } smcg_state_t;
  typedef struct packed {
    logic core_clock_domain;
    logic program_memory_clock_domain;
    logic peripheral_clock_domain;
    logic converter_clock_domain;
    logic async_timer_clock_domain;
    logic main_osc;
    logic timer_osc;
  } smcg_clk_en_t;
  typedef struct packed {
    logic ext_reset;
    logic wdt_reset;
    logic bod_reset;
    logic twi_match;
    logic timer2_ovf;
    logic timer2_cmp;
    logic nvm_ready;
    logic adc_done;
    logic other_io;
    logic irq0_level;
    logic irq1_level;
    logic irq0_any;
    logic irq1_any;
    logic irq2;
  } smcg_wake_t;
endpackage

//--- hdl/smcg_wake_filter.sv
`timescale 1ns/10ps
`include "smcg_cfg.svh"
module smcg_wake_filter (
  input  wire logic [2:0]         mode,
  input  wire logic               async_clocking_bit,
  input  wire logic               t2_ovf_ie,
  input  wire logic               t2_cmp_ie,
  input  wire logic               global_ie,
  input  wire smcg_pkg::smcg_wake_t src,
  output logic                    irq_wake,
  output logic                    rst_wake
);
  import smcg_pkg::*;
  logic ext_lvl;
  // Edge-only irq0/irq1 wake only in Idle
  assign ext_lvl = src.irq0_level | src.irq1_level | src.irq2;
  assign rst_wake = src.ext_reset | src.wdt_reset | src.bod_reset;
  always_comb begin
    irq_wake = 1'b0;
    case (mode)
      `SMCG_MODE_IDLE:   irq_wake = ext_lvl | src.irq0_any | src.irq1_any | src.twi_match
                                  | src.timer2_ovf | src.timer2_cmp | src.nvm_ready
                                  | src.adc_done | src.other_io;
      `SMCG_MODE_ADC_NR: irq_wake = ext_lvl | src.twi_match | src.timer2_ovf
                                  | src.timer2_cmp | src.nvm_ready | src.adc_done;
      `SMCG_MODE_PDOWN,
      `SMCG_MODE_STBY:   irq_wake = ext_lvl | src.twi_match;
      `SMCG_MODE_PSAVE,
      `SMCG_MODE_XSTBY:  irq_wake = ext_lvl | src.twi_match
                                  | (async_clocking_bit & global_ie
                                     & ((src.timer2_ovf & t2_ovf_ie)
                                        | (src.timer2_cmp & t2_cmp_ie)));
      default:           irq_wake = 1'b0;
    endcase
  end
endmodule

//--- hdl/smcg_top.sv
`timescale 1ns/10ps
`include "smcg_cfg.svh"
module smcg_top #(
  parameter int CNT_W = `SMCG_CNT_W
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic [7:0]           power_ctrl,
  input  wire logic                 sleep_op,
  input  wire logic                 crystal_selected,
  input  wire logic [CNT_W-1:0]     startup_cycles,
  input  wire logic                 async_clocking_bit,
  input  wire logic                 t2_ovf_ie,
  input  wire logic                 t2_cmp_ie,
  input  wire logic                 global_ie,
  input  wire logic                 adc_enabled,
  input  wire smcg_pkg::smcg_wake_t wake_src,
  output smcg_pkg::smcg_clk_en_t    clk_en,
  output logic                      adc_start,
  output logic                      asleep,
  output logic                      core_stall,
  output logic                      irq_service,
  output logic                      reset_restart
);
  import smcg_pkg::*;
  smcg_state_t          st_r, st_nxt;
  logic [2:0]           mode_r, mode_nxt;
  logic [CNT_W-1:0]     cnt_r, cnt_nxt;
  smcg_clk_en_t         clk_r, clk_nxt;
  logic                 adc_r, adc_nxt;
  logic                 svc_r, svc_nxt;
  logic                 rrs_r, rrs_nxt;
  logic [2:0]           code;
  logic                 permit;
  logic                 valid_mode;
  logic                 irq_wake;
  logic                 rst_wake;
  smcg_clk_en_t         run_clk;
  smcg_clk_en_t         sleep_clk;
  logic [CNT_W-1:0]     wake_wait;

  assign code   = {power_ctrl[7], power_ctrl[5], power_ctrl[4]};
  assign permit = power_ctrl[`SMCG_PERMIT_BIT];
  assign run_clk = '1;

  smcg_wake_filter u_wake (
    .mode               (mode_r),
    .async_clocking_bit (async_clocking_bit),
    .t2_ovf_ie          (t2_ovf_ie),
    .t2_cmp_ie          (t2_cmp_ie),
    .global_ie          (global_ie),
    .src                (wake_src),
    .irq_wake           (irq_wake),
    .rst_wake           (rst_wake)
  );

  always_comb begin
    valid_mode = 1'b1;
    case (code)
      `SMCG_MODE_RSV4,
      `SMCG_MODE_RSV5:  valid_mode = 1'b0;
      `SMCG_MODE_STBY,
      `SMCG_MODE_XSTBY: valid_mode = crystal_selected;
      default:          valid_mode = 1'b1;
    endcase
  end

  always_comb begin
    sleep_clk = '0;
    case (code)
      `SMCG_MODE_IDLE: begin
        sleep_clk = run_clk;
        sleep_clk.core_clock_domain = 1'b0;
        sleep_clk.program_memory_clock_domain = 1'b0;
        sleep_clk.timer_osc = async_clocking_bit;
      end
      `SMCG_MODE_ADC_NR: begin
        sleep_clk.converter_clock_domain = 1'b1;
        sleep_clk.async_timer_clock_domain = 1'b1;
        sleep_clk.main_osc = 1'b1;
        sleep_clk.timer_osc = async_clocking_bit;
      end
      `SMCG_MODE_PDOWN: sleep_clk = '0;
      `SMCG_MODE_PSAVE: begin
        sleep_clk.async_timer_clock_domain = async_clocking_bit;
        sleep_clk.timer_osc = async_clocking_bit;
      end
      `SMCG_MODE_STBY: sleep_clk.main_osc = 1'b1;
      `SMCG_MODE_XSTBY: begin
        sleep_clk.main_osc = 1'b1;
        sleep_clk.async_timer_clock_domain = async_clocking_bit;
        sleep_clk.timer_osc = async_clocking_bit;
      end
      default: sleep_clk = run_clk;
    endcase
  end

  // Oscillator stopped modes wait the fuse start-up; Standby modes fixed six
  always_comb begin
    wake_wait = '0;
    case (mode_r)
      `SMCG_MODE_PDOWN,
      `SMCG_MODE_PSAVE: wake_wait = startup_cycles;
      `SMCG_MODE_STBY,
      `SMCG_MODE_XSTBY: wake_wait = CNT_W'(`SMCG_STBY_WAKE_CYC);
      default:          wake_wait = '0;
    endcase
  end

  always_comb begin
    st_nxt   = st_r;
    mode_nxt = mode_r;
    cnt_nxt  = cnt_r;
    clk_nxt  = clk_r;
    adc_nxt  = 1'b0;
    svc_nxt  = 1'b0;
    rrs_nxt  = 1'b0;
    case (st_r)
      SMCG_ST_RUN: begin
        clk_nxt = run_clk;
        if (sleep_op && permit && valid_mode) begin
          st_nxt   = SMCG_ST_SLEEP;
          mode_nxt = code;
          clk_nxt  = sleep_clk;
          adc_nxt  = adc_enabled && (code == `SMCG_MODE_IDLE ||
                                     code == `SMCG_MODE_ADC_NR);
        end
      end
      SMCG_ST_SLEEP: begin
        if (rst_wake) begin
          st_nxt  = SMCG_ST_RUN;
          clk_nxt = run_clk;
          rrs_nxt = 1'b1;
        end else if (irq_wake) begin
          clk_nxt = run_clk;
          if (wake_wait == '0) begin
            st_nxt  = SMCG_ST_STALL;
            cnt_nxt = CNT_W'(`SMCG_STALL_CYC - 1);
          end else begin
            st_nxt  = SMCG_ST_START;
            cnt_nxt = wake_wait - CNT_W'(1);
          end
        end
      end
      SMCG_ST_START: begin
        if (cnt_r == '0) begin
          st_nxt  = SMCG_ST_STALL;
          cnt_nxt = CNT_W'(`SMCG_STALL_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      SMCG_ST_STALL: begin
        if (cnt_r == '0) begin
          st_nxt  = SMCG_ST_RUN;
          svc_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      default: begin
        st_nxt  = SMCG_ST_RUN;
        clk_nxt = run_clk;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r   <= SMCG_ST_RUN;
      mode_r <= `SMCG_MODE_IDLE;
      cnt_r  <= '0;
      clk_r  <= '1;
      adc_r  <= 1'b0;
      svc_r  <= 1'b0;
      rrs_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
      cnt_r  <= cnt_nxt;
      clk_r  <= clk_nxt;
      adc_r  <= adc_nxt;
      svc_r  <= svc_nxt;
      rrs_r  <= rrs_nxt;
    end
  end

  assign clk_en        = clk_r;
  assign adc_start     = adc_r;
  assign asleep        = (st_r == SMCG_ST_SLEEP);
  assign core_stall    = (st_r != SMCG_ST_RUN);
  assign irq_service   = svc_r;
  assign reset_restart = rrs_r;

  sequence enter_s;
    st_r == SMCG_ST_RUN && sleep_op && permit && valid_mode;
  endsequence

  // Six start-up plus four stall cycles, split to keep repeats short
  sequence stby_stall_s;
    core_stall [*8] ##1 core_stall [*2];
  endsequence

  no_permit_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r == SMCG_ST_RUN && !permit) |=> !asleep)
    else $error("Slept without permit");
  enter_sleep_a: assert property (@(posedge sys_clk) disable iff (srst)
    enter_s |=> asleep)
    else $error("Sleep not entered");
  idle_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    (enter_s and code == `SMCG_MODE_IDLE) |=> (!clk_en.core_clock_domain &&
      clk_en.peripheral_clock_domain && clk_en.main_osc))
    else $error("Idle clocks wrong");
  adc_start_a: assert property (@(posedge sys_clk) disable iff (srst)
    (enter_s and code == `SMCG_MODE_ADC_NR and adc_enabled) |=> adc_start)
    else $error("No conversion start");
  pdown_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    (enter_s and code == `SMCG_MODE_PDOWN) |=> (clk_en == '0))
    else $error("Power-down clocks running");
  rsv_nop_a: assert property (@(posedge sys_clk) disable iff (srst)
    (sleep_op && code inside {`SMCG_MODE_RSV4, `SMCG_MODE_RSV5} && st_r == SMCG_ST_RUN)
    |=> (!asleep && clk_en == '1))
    else $error("Reserved code slept");
  stby_xtal_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_r == SMCG_ST_RUN && sleep_op && !crystal_selected && code[2:1] == 2'h3)
    |=> !asleep)
    else $error("Standby without crystal");
  rst_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
    (asleep && rst_wake) |=> (reset_restart && !core_stall && !irq_service))
    else $error("Reset wake wrong");
  stby_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
    (asleep && !rst_wake && irq_wake && mode_r == `SMCG_MODE_STBY)
    |=> stby_stall_s ##1 irq_service)
    else $error("Standby wake timing wrong");
  pdown_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
    (asleep && mode_r == `SMCG_MODE_PDOWN && !rst_wake && !wake_src.irq0_level &&
     !wake_src.irq1_level && !wake_src.irq2 && !wake_src.twi_match) |=> asleep)
    else $error("Power-down woke wrongly");
endmodule

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import smcg_pkg::*;
  logic         sys_clk;
  logic         srst;
  logic [7:0]   power_ctrl;
  logic         sleep_op;
  logic         crystal_selected;
  logic [15:0]  startup_cycles;
  logic         async_clocking_bit;
  logic         t2_ovf_ie;
  logic         t2_cmp_ie;
  logic         global_ie;
  logic         adc_enabled;
  smcg_wake_t   wake_src;
  smcg_clk_en_t clk_en;
  logic         adc_start;
  logic         asleep;
  logic         core_stall;
  logic         irq_service;
  logic         reset_restart;
  int           bad_count;
  int           checks;
  int           cyc;
  int           adc_cnt;
  int           svc_cnt;

  smcg_top u_smcg_top (
    .sys_clk            (sys_clk),
    .srst               (srst),
    .power_ctrl         (power_ctrl),
    .sleep_op           (sleep_op),
    .crystal_selected   (crystal_selected),
    .startup_cycles     (startup_cycles),
    .async_clocking_bit (async_clocking_bit),
    .t2_ovf_ie          (t2_ovf_ie),
    .t2_cmp_ie          (t2_cmp_ie),
    .global_ie          (global_ie),
    .adc_enabled        (adc_enabled),
    .wake_src           (wake_src),
    .clk_en             (clk_en),
    .adc_start          (adc_start),
    .asleep             (asleep),
    .core_stall         (core_stall),
    .irq_service        (irq_service),
    .reset_restart      (reset_restart)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Pulse widths are judged by counting high cycles, not by exact sampling
  always @(posedge sys_clk) begin
    cyc++;
    if (adc_start === 1'b1) adc_cnt++;
    if (irq_service === 1'b1) svc_cnt++;
    if (cyc >= 12000) begin
      bad_count++;
      report_and_stop();
    end
  end

  function automatic smcg_clk_en_t exp_clk(input logic [2:0] m, input logic a);
    case (m)
      3'h0: return {5'h07, 1'b1, a};
      3'h1: return {5'h03, 1'b1, a};
      3'h3: return {4'h0, a, 1'b0, a};
      3'h6: return 7'h02;
      3'h7: return {4'h0, a, 1'b1, a};
      default: return 7'h00;
    endcase
  endfunction

  function automatic logic exp_irq(input logic [2:0] m, input smcg_wake_t w);
    logic base;
    logic t2;
    base = w.twi_match | w.irq0_level | w.irq1_level | w.irq2;
    t2 = async_clocking_bit & global_ie &
         ((w.timer2_ovf & t2_ovf_ie) | (w.timer2_cmp & t2_cmp_ie));
    case (m)
      3'h0: return |w[10:0];
      3'h1: return base | w.timer2_ovf | w.timer2_cmp | w.nvm_ready | w.adc_done;
      3'h2, 3'h6: return base;
      3'h3, 3'h7: return base | t2;
      default: return 1'b0;
    endcase
  endfunction

  task automatic wake(input smcg_wake_t w, input int exp_n, input logic exp_rst,
                      input logic [8:0] exp_end);
    int n;
    @(posedge sys_clk);
    wake_src <= w;
    #1;
    svc_cnt = 0;
    for (n = 1; n < 40; n++) begin
      @(posedge sys_clk);
      #1;
      if (irq_service === 1'b1 || reset_restart === 1'b1) break;
    end
    check(16'(n), 16'(exp_n));
    if (n < 40) check(reset_restart, exp_rst);
    @(posedge sys_clk);
    wake_src <= '0;
    power_ctrl[6] <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(16'(svc_cnt), 16'(n < 40 && !exp_rst));
    check({asleep, core_stall, clk_en}, exp_end);
  endtask

  task automatic run_case(input logic [2:0] m, input logic permit, input logic xtal,
                          input smcg_wake_t w);
    logic       ok;
    int         st;
    smcg_wake_t rw;
    logic [4:0] cfg;
    smcg_clk_en_t exp_c;
    int         wn;
    ok = permit && m[2:1] != 2'b10 && (!m[2] || xtal);
    st = $urandom_range(0, 3);
    rw = '0;
    rw.ext_reset = 1'b1;
    cfg = 5'($urandom);
    // Timer-kept modes only used with async clocking on
    if (m[1:0] == 2'h3) cfg[3] = 1'b1;
    @(posedge sys_clk);
    crystal_selected <= xtal;
    {adc_enabled, async_clocking_bit, t2_ovf_ie, t2_cmp_ie, global_ie} <= cfg;
    power_ctrl <= {m[2], permit, m[1], m[0], 4'($urandom)};
    startup_cycles <= 16'(st);
    sleep_op <= 1'b1;
    #1;
    adc_cnt = 0;
    @(posedge sys_clk);
    sleep_op <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    exp_c = ok ? exp_clk(m, async_clocking_bit) : 7'h7f;
    wn = 5 + (m[2] ? 6 : (m[1] ? st : 0));
    check({asleep, core_stall}, {2{ok}});
    check(clk_en, exp_c);
    check(16'(adc_cnt), 16'(ok && adc_enabled && m < 3'h2));
    if (!ok) wake(w, 40, 1'b0, 9'h07f);
    else if (|w[13:11]) wake(w, 1, 1'b1, 9'h07f);
    else if (exp_irq(m, w)) wake(w, wn, 1'b0, 9'h07f);
    else begin
      // No wake source: still asleep with the sleep clocks
      wake(w, 40, 1'b0, {2'b11, exp_c});
      wake(rw, 1, 1'b1, 9'h07f);
    end
  endtask

  initial begin
    smcg_wake_t w;
    void'($urandom(32'h9021));
    bad_count = 0;
    checks = 0;
    cyc = 0;
    srst = 1'b1;
    power_ctrl = 8'h00;
    sleep_op = 1'b0;
    crystal_selected = 1'b1;
    startup_cycles = 16'h0003;
    {adc_enabled, async_clocking_bit, t2_ovf_ie, t2_cmp_ie, global_ie} = 5'h00;
    wake_src = '0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({asleep, core_stall, clk_en}, 9'h07f);
    // Blocks of eight: no permit, then permit, no crystal, reset wake
    for (int i = 0; i < 96; i++) begin
      // Comparator wake counts as other_io, gated by software
      w = smcg_wake_t'(14'h0001 << $urandom_range(0, 10));
      if (i >= 80) w = w | smcg_wake_t'(14'h0800 << $urandom_range(0, 2));
      run_case(i[2:0], i >= 8, i / 8 != 2, w);
    end
    report_and_stop();
  end
endmodule
